// *** include/psr_pkg.sv ***
package psr_pkg;

	// Clock rate in kHz, period 50 ns.
	localparam int CLK_KHZ = 20000;
	localparam int CLK_NS = 50;

	// Pin timing figures, in their own units.
	localparam int ENABLE_PULSE_NS = 100;
	localparam int PRECHARGE_NS = 50;
	localparam int AUTO_REFRESH_PULSE_NS = 30;
	localparam int AUTO_REFRESH_PULSE_MAX_NS = 8000;
	localparam int REFRESH_CYCLE_NS = 160;
	localparam int REFRESH_TO_ENABLE_NS = 50;
	localparam int SELF_REFRESH_ENTRY_NS = 8000;
	localparam int SELF_REFRESH_EXIT_NS = 190;
	localparam int REFRESH_PERIOD_MS = 8;
	localparam int POWER_UP_US = 100;
	localparam int ROWS = 512;

	// Least times round up to whole cycles.
	localparam int ENABLE_PULSE_CYC = (ENABLE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
	// The auto pulse is one cycle longer than the minimum, well under its maximum.
	localparam int AUTO_PULSE_CYC = (AUTO_REFRESH_PULSE_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int AUTO_PULSE_MAX_CYC = AUTO_REFRESH_PULSE_MAX_NS / CLK_NS;
	localparam int AUTO_HIGH_CYC = (REFRESH_CYCLE_NS + CLK_NS - 1) / CLK_NS - AUTO_PULSE_CYC + 1;
	localparam int RFD_CYC = (REFRESH_TO_ENABLE_NS + CLK_NS - 1) / CLK_NS;
	// Two cycles of margin over the entry width.
	localparam int SELF_ENTRY_CYC = (SELF_REFRESH_ENTRY_NS + CLK_NS - 1) / CLK_NS + 2;
	localparam int SELF_EXIT_CYC = (SELF_REFRESH_EXIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int POWER_UP_CYC = POWER_UP_US * 1000 / CLK_NS;
	// Spacing of refresh requests: longest time, rounds down.
	localparam int REFRESH_INTERVAL_CYC = REFRESH_PERIOD_MS * CLK_KHZ / ROWS;

	// Widths and reset values.
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

	// Host request.
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} psr_req_t;

	// Pins toward the memory, all active as named.
	typedef struct packed {
		logic enable_low_active_n;
		logic enable_high_active;
		logic output_enable_n;
		logic write_enable_n;
		logic refresh_n;
		logic [ADDR_W-1:0] address_bus;
	} psr_pins_t;

	// Controller states, one-hot.
	typedef enum logic [8:0] {
		ST_POWER = 9'h001,
		ST_IDLE = 9'h002,
		ST_ACCESS = 9'h004,
		ST_PRECH = 9'h008,
		ST_AUTO_LO = 9'h010,
		ST_AUTO_HI = 9'h020,
		ST_SELF = 9'h040,
		ST_EXIT = 9'h080,
		ST_RFD = 9'h100
	} psr_state_t;

endpackage

// *** sim/psr_host_properties.sv ***
`timescale 1ns/100ps
// Watches the controller's ports for pin order and handshake timing.
module psr_chk (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Host side.
	input wire logic req_valid,
	input wire psr_pkg::psr_req_t req,
	input wire logic req_ready,
	input wire logic rsp_valid,
	// Memory side.
	input wire psr_pkg::psr_pins_t pins,
	input wire logic [7:0] data_pins_out,
	input wire logic data_pins_oe_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire take = req_valid && req_ready; // A request is taken at this edge.
	refresh_idle_a: assert property (!pins.refresh_n |-> pins.enable_low_active_n)
		else $error("refresh low inside a cycle");
	cycle_start_a: assert property (take |=> !pins.enable_low_active_n && pins.address_bus == $past(req.addr))
		else $error("cycle start or address wrong");
	write_start_a: assert property (take && req.write |=> !pins.write_enable_n && !data_pins_oe_n)
		else $error("write start wrong");
	write_data_a: assert property (take && req.write |=> data_pins_out == $past(req.wdata))
		else $error("write data wrong");
	read_answer_a: assert property (take && !req.write |-> ##5 rsp_valid)
		else $error("read answer late or missing");
	enable_width_a: assert property ($fell(pins.enable_low_active_n) |=> !pins.enable_low_active_n ##1 pins.enable_low_active_n)
		else $error("enable pulse width wrong");
	auto_width_a: assert property ($fell(pins.refresh_n) |=> !pins.refresh_n)
		else $error("refresh pulse too short");
	exit_gap_a: assert property ($rose(pins.refresh_n) && !$past(pins.refresh_n, 3) |-> pins.enable_low_active_n [*4])
		else $error("enable too soon after self refresh");
endmodule // psr_chk

bind psr_host psr_chk u_chk (.ref_clk, .rst, .req_valid, .req, .req_ready, .rsp_valid, .pins, .data_pins_out,
	.data_pins_oe_n);

// *** sim/psr_host_tb_top.sv ***
`timescale 1ns/100ps
// Controller bench: clock, reset, device model and scenarios.
module psr_host_tb_top;
	localparam int PU = 5; // Short power-up pause.
	localparam int RI = 40; // Short refresh spacing.
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	psr_pkg::psr_req_t req = '0;
	logic standby_req = 1'b0;
	logic req_ready, rsp_valid, standby_active, data_pins_oe_n;
	logic [7:0] rsp_rdata, data_pins_in, data_pins_out, dq;
	psr_pkg::psr_pins_t pins;
	int err_total = 0;
	int total_checks = 0;
	// The controller wins the data wires while it drives them.
	assign data_pins_in = data_pins_oe_n ? dq : data_pins_out;
	psr_host #(.POWER_UP_CYCLES(PU), .REFRESH_INTERVAL(RI)) DUT (.ref_clk, .rst, .req_valid, .req, .req_ready,
		.rsp_valid, .rsp_rdata, .standby_req, .standby_active, .pins, .data_pins_in, .data_pins_out, .data_pins_oe_n);
	psr_mem mem_model (.pins(pins), .din(data_pins_out), .dq(dq));
	initial forever #25 ref_clk = ~ref_clk;
	// Compares and counts; a mismatch is reported at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Byte pattern that differs for every test address.
	function automatic logic [7:0] pat(input logic [16:0] a);
		return a[7:0] + a[16:9] + 8'h3C;
	endfunction
	// One request, held until taken; a read is judged when its answer stands.
	task automatic bus_op(input logic w, input logic [16:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= '{w, a, d};
		@(posedge ref_clk);
		while (req_ready !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		chk(req_ready, 1);
		req_valid <= 1'b0;
		if (!w) begin
			// The byte passes two input flops, so the answer stands five edges after the take.
			repeat (5) @(posedge ref_clk);
			chk(rsp_valid, 1);
			chk(rsp_rdata, d);
		end
	endtask
	// Nothing may start during the power-up pause.
	task automatic power_up;
		repeat (PU - 1) begin
			@(posedge ref_clk);
			chk(req_ready, 0);
			chk(pins.enable_low_active_n, 1);
		end
	endtask
	// Boundary addresses written, then read back in reverse order.
	task automatic rw_scen;
		logic [16:0] a [4] = '{17'h00000, 17'h1FFFF, 17'h001FF, 17'h10200};
		for (int i = 0; i < 4; i++) bus_op(1'b1, a[i], pat(a[i]));
		for (int i = 3; i >= 0; i--) bus_op(1'b0, a[i], pat(a[i]));
	endtask
	// Idle time must be filled with auto refresh pulses.
	task automatic refresh_scen;
		int c0;
		c0 = mem_model.auto_cnt;
		repeat (10 * RI) @(posedge ref_clk);
		chk(mem_model.auto_cnt - c0 >= 9, 1);
	endtask
	// Standby enters self refresh, refuses requests, then exits with the gap kept.
	task automatic standby_scen;
		@(posedge ref_clk);
		standby_req <= 1'b1;
		repeat (260) @(posedge ref_clk);
		chk(standby_active, 1);
		chk(mem_model.self_on, 1);
		chk(req_ready, 0);
		standby_req <= 1'b0;
		bus_op(1'b0, 17'h1FFFF, pat(17'h1FFFF));
		chk(mem_model.slips, 0);
	endtask
	// Verdict and end of run.
	task automatic complete_run;
		if (err_total == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		power_up;
		rw_scen;
		refresh_scen;
		standby_scen;
		complete_run;
	end
	// Cuts a hang short well beyond the expected run.
	initial begin
		#(20000 * 50);
		err_total++;
		complete_run;
	end
endmodule // psr_host_tb_top

// *** sim/psr_mem_model.sv ***
`timescale 1ns/100ps
// Behavioural memory device; it also counts refresh pulses and controller slips.
module psr_mem (
	// Pins from the controller.
	input wire psr_pkg::psr_pins_t pins,
	input wire logic [7:0] din,
	// Data back toward the controller.
	output logic [7:0] dq
);
	logic [7:0] mem [0:131071]; // Storage array.
	logic [16:0] la = '0; // Address taken at cycle start.
	logic [8:0] row = '0; // Internal refresh row counter.
	logic wr = 1'b0; // A write cycle is open.
	logic self_on = 1'b0; // Self refresh running.
	int auto_cnt = 0; // Pulses that refreshed a row.
	int slips = 0; // Controller timing slips.
	realtime f_fall = 0.0; // Last fall of the refresh input.
	realtime f_rise = -1.0e6; // Last rise of the refresh input.
	wire en = !pins.enable_low_active_n && pins.enable_high_active;
	wire rd = en && !pins.output_enable_n && pins.write_enable_n;
	// A released bus shows the inverse byte, so stale data can never pass.
	assign dq = rd ? mem[la] : ~mem[la];
	// Cycle start takes the address, may open a write and counts a start too soon after self refresh as a slip.
	always @(posedge en) begin
		la = pins.address_bus;
		wr = !pins.write_enable_n;
		if (f_rise - f_fall >= 8000.0 && $realtime - f_rise < 190.0) slips++;
	end
	// The byte lands at the first of the two rising controls.
	always @(negedge en or posedge pins.write_enable_n) begin
		if (wr) mem[la] = din;
		wr = 1'b0;
	end
	// Of the refresh falls, only a deselected one advances the row counter.
	always @(negedge pins.refresh_n) begin
		f_fall = $realtime;
		if (en) slips++;
		else begin
			row++;
			auto_cnt++;
		end
	end
	// A rise ends self refresh; the power-up edge is ignored.
	always @(posedge pins.refresh_n) begin
		f_rise = $realtime;
		self_on = 1'b0;
		if (f_fall > 0.0 && f_rise - f_fall < 30.0) slips++;
	end
	// Polling is coarse, which is ample against an 8 us entry width.
	always #1000 self_on = !pins.refresh_n && !en && $realtime - f_fall >= 8000.0;
	always #150000 if (self_on) row++;
endmodule // psr_mem

// *** verilog/psr_host.sv ***
`timescale 1ns/100ps

module psr_host #(
	parameter int POWER_UP_CYCLES = psr_pkg::POWER_UP_CYC,
	parameter int REFRESH_INTERVAL = psr_pkg::REFRESH_INTERVAL_CYC
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Host request port.
	input wire logic req_valid,
	input wire psr_pkg::psr_req_t req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [psr_pkg::DATA_W-1:0] rsp_rdata,
	// Standby control from the system.
	input wire logic standby_req,
	output logic standby_active,
	// Memory pins.
	output psr_pkg::psr_pins_t pins,
	input wire logic [psr_pkg::DATA_W-1:0] data_pins_in,
	output logic [psr_pkg::DATA_W-1:0] data_pins_out,
	output logic data_pins_oe_n
);

	// State, down counter, refresh timer and owed-refresh flag.
	psr_pkg::psr_state_t state_q, state_d;
	logic [psr_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [psr_pkg::CNT_W-1:0] rtmr_q, rtmr_d;
	logic rpend_q, rpend_d;
	// Latched request, so the end of the cycle knows a read from a write.
	psr_pkg::psr_req_t cur_q, cur_d;
	// Output flops.
	psr_pkg::psr_pins_t pins_q, pins_d;
	logic [psr_pkg::DATA_W-1:0] dout_q, dout_d, rdata_q, rdata_d;
	logic oe_n_q, oe_n_d, ready_q, ready_d, rsp_q, rsp_d, stby_q, stby_d;
	// Two-stage synchroniser for the read data pins.
	logic [psr_pkg::DATA_W-1:0] din_s1_q, din_s2_q;

	// Converts a cycle count into the counter width.
	function automatic logic [psr_pkg::CNT_W-1:0] cyc(input int n);
		return psr_pkg::CNT_W'(n - 1);
	endfunction

	// Read data crosses from the pins; only the second stage is used.
	always_ff @(posedge ref_clk) begin
		din_s1_q <= data_pins_in;
		din_s2_q <= din_s1_q;
	end

	// Next-state logic for the whole sequencer.
	always_comb begin
		state_d = state_q;
		cnt_d = (cnt_q == psr_pkg::CNT_ZERO) ? cnt_q : cnt_q - 1'b1;
		rtmr_d = rtmr_q - 1'b1;
		rpend_d = rpend_q;
		cur_d = cur_q;
		pins_d = pins_q;
		dout_d = dout_q;
		oe_n_d = oe_n_q;
		rdata_d = rdata_q;
		ready_d = 1'b0;
		rsp_d = 1'b0;
		stby_d = stby_q;
		// Refresh timer: one row owed per interval, 512 per 8 ms.
		if (rtmr_q == psr_pkg::CNT_ZERO) begin
			rtmr_d = cyc(REFRESH_INTERVAL);
			if (state_q != psr_pkg::ST_SELF) begin
				rpend_d = 1'b1;
			end
		end
		case (state_q)
			psr_pkg::ST_POWER: begin
				// Deselected, refresh high, for the power-up pause.
				if (cnt_q == psr_pkg::CNT_ZERO) begin
					state_d = psr_pkg::ST_IDLE;
					ready_d = 1'b1;
				end
			end
			psr_pkg::ST_IDLE: begin
				// A request met with ready high is always taken, so ready never lies to the host.
				// An owed refresh then waits one access at most, far inside its interval.
				if (req_valid && ready_q) begin
					// Address, controls and the enable edge leave together.
					cur_d = req;
					pins_d.address_bus = req.addr;
					pins_d.enable_low_active_n = 1'b0;
					pins_d.write_enable_n = ~req.write;
					pins_d.output_enable_n = req.write;
					dout_d = req.wdata;
					oe_n_d = ~req.write;
					cnt_d = cyc(psr_pkg::ENABLE_PULSE_CYC);
					state_d = psr_pkg::ST_ACCESS;
				end else if (rpend_q) begin
					// Refresh only starts from deselected.
					pins_d.refresh_n = 1'b0;
					cnt_d = cyc(psr_pkg::AUTO_PULSE_CYC);
					// A row owed in this very cycle stays owed: the set wins over the clear.
					rpend_d = (rtmr_q == psr_pkg::CNT_ZERO);
					state_d = psr_pkg::ST_AUTO_LO;
				end else if (standby_req) begin
					pins_d.refresh_n = 1'b0;
					cnt_d = cyc(psr_pkg::SELF_ENTRY_CYC);
					state_d = psr_pkg::ST_SELF;
				end else begin
					ready_d = 1'b1;
				end
			end
			psr_pkg::ST_ACCESS: begin
				// Enable and write enable rise together; data still held.
				if (cnt_q == psr_pkg::CNT_ZERO) begin
					pins_d.enable_low_active_n = 1'b1;
					pins_d.write_enable_n = 1'b1;
					pins_d.output_enable_n = 1'b1;
					cnt_d = cyc(psr_pkg::PRECHARGE_CYC);
					state_d = psr_pkg::ST_PRECH;
				end
			end
			psr_pkg::ST_PRECH: begin
				// Zero data hold: release bus one cycle after the enable rises.
				oe_n_d = 1'b1;
				if (cnt_q == psr_pkg::CNT_ZERO) begin
					cnt_d = cyc(psr_pkg::RFD_CYC);
					state_d = psr_pkg::ST_RFD;
				end
			end
			psr_pkg::ST_RFD: begin
				// Gap from enable high to a refresh fall, and precharge.
				if (cnt_q == psr_pkg::CNT_ZERO) begin
					// The byte sampled by the first stage at the enable rise has only now reached the
					// second stage; this relies on one precharge and one gap cycle, as the package sets.
					if (!cur_q.write) begin
						rdata_d = din_s2_q;
						rsp_d = 1'b1;
					end
					state_d = psr_pkg::ST_IDLE;
					ready_d = ~rpend_q & ~standby_req;
				end
			end
			psr_pkg::ST_AUTO_LO: begin
				if (cnt_q == psr_pkg::CNT_ZERO) begin
					pins_d.refresh_n = 1'b1;
					cnt_d = cyc(psr_pkg::AUTO_HIGH_CYC);
					state_d = psr_pkg::ST_AUTO_HI;
				end
			end
			psr_pkg::ST_AUTO_HI: begin
				// Refresh precharge and cycle time before anything else.
				if (cnt_q == psr_pkg::CNT_ZERO) begin
					state_d = psr_pkg::ST_IDLE;
				end
			end
			psr_pkg::ST_SELF: begin
				// Device runs its own timer; we only hold refresh low.
				if (cnt_q == psr_pkg::CNT_ZERO) begin
					stby_d = 1'b1;
				end
				if (!standby_req && cnt_q == psr_pkg::CNT_ZERO) begin
					pins_d.refresh_n = 1'b1;
					stby_d = 1'b0;
					cnt_d = cyc(psr_pkg::SELF_EXIT_CYC);
					state_d = psr_pkg::ST_EXIT;
				end
			end
			psr_pkg::ST_EXIT: begin
				// Owe a fresh row after the long standby.
				if (cnt_q == psr_pkg::CNT_ZERO) begin
					rpend_d = 1'b1;
					state_d = psr_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = psr_pkg::ST_IDLE;
			end
		endcase
	end

	// Registers; high enable tied asserted, so its timing around the low one holds.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= psr_pkg::ST_POWER;
			cnt_q <= cyc(POWER_UP_CYCLES);
			rtmr_q <= cyc(REFRESH_INTERVAL);
			rpend_q <= 1'b0;
			cur_q <= '0;
			pins_q <= '{enable_low_active_n: 1'b1, enable_high_active: 1'b1, output_enable_n: 1'b1,
				write_enable_n: 1'b1, refresh_n: 1'b1, address_bus: '0};
			dout_q <= '0;
			oe_n_q <= 1'b1;
			rdata_q <= '0;
			ready_q <= 1'b0;
			rsp_q <= 1'b0;
			stby_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			rtmr_q <= rtmr_d;
			rpend_q <= rpend_d;
			cur_q <= cur_d;
			pins_q <= pins_d;
			dout_q <= dout_d;
			oe_n_q <= oe_n_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			rsp_q <= rsp_d;
			stby_q <= stby_d;
		end
	end

	// Outputs come straight from flops.
	assign pins = pins_q;
	assign data_pins_out = dout_q;
	assign data_pins_oe_n = oe_n_q;
	assign req_ready = ready_q;
	assign rsp_valid = rsp_q;
	assign rsp_rdata = rdata_q;
	assign standby_active = stby_q;

endmodule // psr_host
